/* File: hdl/bel_pkg.sv */
/*
 * Package for the bus error logging register bank: offsets, bit positions,
 * reset values and widths.
 * Assumes the node decodes its own address space and presents word offsets.
 */
package bel_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CID_W = 6;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_BUS_ERROR_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_FAILING_ADDRESS_LOG = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_RESPONDER_ERROR_ADDRESS_LOG = 8'h0C;

    // ------------------------------------------------------------
    // Status bit positions
    // ------------------------------------------------------------
    localparam int BIT_WRITE_SEQ = 22;
    localparam int BIT_RID_NOACK = 21;
    localparam int BIT_WD_NOACK = 20;
    localparam int BIT_CRD = 19;
    localparam int BIT_NRR = 18;
    localparam int BIT_RSE = 17;
    localparam int BIT_RER = 16;
    localparam int BIT_CMD_NOACK = 15;
    localparam int BIT_TTO = 13;
    localparam int BIT_NODE_SUM = 12;
    localparam int BIT_SELF_TEST = 10;
    localparam int BIT_CID_LO = 4;
    localparam int BIT_TO_DIS = 2;

    // W1C flag mask, bits 22:13 except 14, plus 10
    localparam logic [DATA_W-1:0] W1C_MASK = 32'h007FA400;
    localparam logic [DATA_W-1:0] STATUS_RESET = 32'h00000400;
    localparam logic [DATA_W-1:0] ADDR_RESET = 32'h00000000;
endpackage : bel_pkg

/* File: hdl/bel_bus_error_logging.sv */
/*
 * Bus error status, failing address log and responder error address log.
 * Assumes event inputs are single-cycle pulses on i_ref_clk from node logic
 * and that register accesses are one-cycle strobes with a word offset.
 */
module bel_bus_error_logging
#(
    parameter int CID_WIDTH = bel_pkg::CID_W
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Register access
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [bel_pkg::ADDR_W-1:0] i_reg_addr,
    input wire logic [bel_pkg::DATA_W-1:0] i_reg_wdata,
    output logic [bel_pkg::DATA_W-1:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // Commander side events
    input wire logic i_cmd_ca_issued,
    input wire logic [bel_pkg::DATA_W-1:0] i_cmd_ca_data,
    input wire logic [CID_WIDTH-1:0] i_cmd_commander_id,
    input wire logic i_crd_resp,
    input wire logic i_read_err_resp,
    input wire logic i_read_seq_err,
    input wire logic i_read_resp_timeout,
    input wire logic i_cmd_retries_failed,
    input wire logic i_grant_timeout,
    input wire logic i_write_data_noack,
    input wire logic i_internal_err,
    // Responder side events
    input wire logic i_rsp_ca_acked,
    input wire logic [bel_pkg::DATA_W-1:0] i_rsp_ca_data,
    input wire logic i_write_seq_err,
    input wire logic i_rid_data_noack,
    input wire logic i_rsp_other_err,
    input wire logic i_node_err_summary,
    // Status outputs
    output logic o_timeout_disable,
    output logic o_fail_lock,
    output logic o_rsp_lock
);
    import bel_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [DATA_W-1:0] flags_r, flags_nxt;
    logic [CID_WIDTH-1:0] fail_cid_r;
    logic timeout_disable_r;
    logic node_sum_r;
    logic [DATA_W-1:0] fail_addr_r;
    logic [DATA_W-1:0] rsp_addr_r;
    logic fail_lock_r, fail_lock_nxt;
    logic rsp_lock_r, rsp_lock_nxt;
    logic rsp_int_lock_r;
    logic [DATA_W-1:0] rdata_r;
    logic rvalid_r;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire sel_status = (i_reg_addr == OFS_BUS_ERROR_STATUS);
    wire sel_fail = (i_reg_addr == OFS_FAILING_ADDRESS_LOG);
    wire sel_rsp = (i_reg_addr == OFS_RESPONDER_ERROR_ADDRESS_LOG);
    wire wr_status = i_reg_wr && sel_status;
    wire [DATA_W-1:0] clr_mask = wr_status ? (i_reg_wdata & W1C_MASK) : '0;

    // Timeout events masked by the disable control
    wire to_allowed = !timeout_disable_r;
    wire ev_nrr = i_read_resp_timeout && to_allowed;
    wire ev_command_noack_flag = i_cmd_retries_failed && to_allowed;
    wire ev_tto = (i_grant_timeout || i_cmd_retries_failed || i_read_resp_timeout) && to_allowed;

    function automatic logic [DATA_W-1:0] bit_at(input int pos, input logic v);
        bit_at = v ? (DATA_W'(1) << pos) : '0;
    endfunction : bit_at

    wire [DATA_W-1:0] set_mask = bit_at(BIT_CRD, i_crd_resp)
        | bit_at(BIT_NRR, ev_nrr)
        | bit_at(BIT_RSE, i_read_seq_err)
        | bit_at(BIT_RER, i_read_err_resp)
        | bit_at(BIT_CMD_NOACK, ev_command_noack_flag)
        | bit_at(BIT_TTO, ev_tto)
        | bit_at(BIT_WRITE_SEQ, i_write_seq_err)
        | bit_at(BIT_RID_NOACK, i_rid_data_noack)
        | bit_at(BIT_WD_NOACK, i_write_data_noack);

    // Set wins over a clear in the same cycle
    assign flags_nxt = ((flags_r & ~clr_mask) | set_mask) & W1C_MASK;

    // Lock causes; the internal error has no flag here, so it holds its own lock
    logic int_lock_r;
    wire fail_cause = i_write_data_noack || ev_nrr || i_read_seq_err || ev_command_noack_flag || ev_tto
        || i_internal_err;
    wire fail_flags_on = |(flags_nxt & (bit_at(BIT_WD_NOACK, 1'b1) | bit_at(BIT_NRR, 1'b1)
        | bit_at(BIT_RSE, 1'b1) | bit_at(BIT_CMD_NOACK, 1'b1) | bit_at(BIT_TTO, 1'b1)));
    assign fail_lock_nxt = fail_flags_on || int_lock_r || i_internal_err;
    wire rsp_cause = i_write_seq_err || i_rid_data_noack || i_rsp_other_err || i_internal_err;
    wire rsp_flags_on = |(flags_nxt & (bit_at(BIT_WRITE_SEQ, 1'b1) | bit_at(BIT_RID_NOACK, 1'b1)));
    assign rsp_lock_nxt = rsp_flags_on || rsp_int_lock_r || i_rsp_other_err || i_internal_err;

    wire fail_capture = i_cmd_ca_issued && !fail_lock_r && !fail_cause;
    wire rsp_capture = i_rsp_ca_acked && !rsp_lock_r && !rsp_cause;

    wire [DATA_W-1:0] status_view = flags_r
        | bit_at(BIT_NODE_SUM, node_sum_r)
        | (DATA_W'(fail_cid_r) << BIT_CID_LO)
        | bit_at(BIT_TO_DIS, timeout_disable_r);
    wire [DATA_W-1:0] cid_field = ((DATA_W'(1) << CID_WIDTH) - DATA_W'(1)) << BIT_CID_LO;
    wire [DATA_W-1:0] rsvd_mask = ~(W1C_MASK | cid_field | bit_at(BIT_NODE_SUM, 1'b1) | bit_at(BIT_TO_DIS, 1'b1));

    wire [DATA_W-1:0] rdata_nxt = sel_status ? status_view
        : sel_fail ? fail_addr_r
        : sel_rsp ? rsp_addr_r : '0;

    // ------------------------------------------------------------
    // Status register
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            flags_r <= STATUS_RESET;
            timeout_disable_r <= 1'b0;
            node_sum_r <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            node_sum_r <= i_node_err_summary;
            if (wr_status) begin
                timeout_disable_r <= i_reg_wdata[BIT_TO_DIS];
            end
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            fail_cid_r <= '0;
        end else if (i_cmd_retries_failed && to_allowed) begin
            fail_cid_r <= i_cmd_commander_id;
        end
    end

    // ------------------------------------------------------------
    // Address logs
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            fail_addr_r <= ADDR_RESET;
            rsp_addr_r <= ADDR_RESET;
            fail_lock_r <= 1'b0;
            rsp_lock_r <= 1'b0;
            int_lock_r <= 1'b0;
            rsp_int_lock_r <= 1'b0;
        end else begin
            if (fail_capture) begin
                fail_addr_r <= i_cmd_ca_data;
            end
            if (rsp_capture) begin
                rsp_addr_r <= i_rsp_ca_data;
            end
            fail_lock_r <= fail_lock_nxt;
            rsp_lock_r <= rsp_lock_nxt;
            // Internal and other causes clear on any write to the status register
            int_lock_r <= (int_lock_r && !wr_status) || i_internal_err;
            rsp_int_lock_r <= (rsp_int_lock_r && !wr_status) || i_rsp_other_err || i_internal_err;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_r <= '0;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r <= i_reg_rd ? rdata_nxt : '0;
            rvalid_r <= i_reg_rd;
        end
    end

    assign o_reg_rdata = rdata_r;
    assign o_reg_rvalid = rvalid_r;
    assign o_timeout_disable = timeout_disable_r;
    assign o_fail_lock = fail_lock_r;
    assign o_rsp_lock = rsp_lock_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_CRD_SET: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_crd_resp |=> flags_r[BIT_CRD]) else $error("crd flag not set");
    AST_NRR_SET: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_read_resp_timeout && !timeout_disable_r) |=> flags_r[BIT_NRR] && flags_r[BIT_TTO])
        else $error("nrr flag not set");
    AST_RSE_SET: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_read_seq_err |=> flags_r[BIT_RSE]) else $error("rse flag not set");
    AST_RER_SET: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_read_err_resp |=> flags_r[BIT_RER]) else $error("rer flag not set");
    AST_COMMAND_NOACK_FLAG_TTO: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        $rose(flags_r[BIT_CMD_NOACK]) |-> flags_r[BIT_TTO]) else $error("command_noack_flag without tto");
    AST_TTO_GRANT: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_grant_timeout && !timeout_disable_r) |=> flags_r[BIT_TTO]) else $error("tto not set");
    AST_SUM_MIRROR: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_node_err_summary |=> status_view[BIT_NODE_SUM]) else $error("summary bit wrong");
    AST_STF_HOLD: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (flags_r[BIT_SELF_TEST] && !(wr_status && i_reg_wdata[BIT_SELF_TEST])) |=> flags_r[BIT_SELF_TEST])
        else $error("self test flag lost");
    AST_CID_STABLE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !i_cmd_retries_failed |=> $stable(fail_cid_r)) else $error("commander id changed");
    AST_TO_DISABLED: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (timeout_disable_r && !flags_r[BIT_TTO]) |=> !flags_r[BIT_TTO]) else $error("tto while disabled");
    AST_FAIL_FROZEN: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        fail_lock_r |=> $stable(fail_addr_r)) else $error("failing log moved while locked");
    AST_FAIL_CAPTURE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        fail_capture |=> fail_addr_r == $past(i_cmd_ca_data)) else $error("failing log missed capture");
    AST_RSP_CAPTURE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        rsp_capture |=> rsp_addr_r == $past(i_rsp_ca_data)) else $error("responder log missed capture");
    AST_RSP_FROZEN: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        rsp_lock_r |=> $stable(rsp_addr_r)) else $error("responder log moved while locked");
    AST_W1C: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (wr_status && i_reg_wdata[BIT_RER] && !i_read_err_resp) |=> !flags_r[BIT_RER])
        else $error("w1c failed");
    AST_RSVD_ZERO: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        o_reg_rvalid |-> (o_reg_rdata[14] == 1'b0 || !$past(sel_status)) && (o_reg_rdata[11] == 1'b0
        || !$past(sel_status))) else $error("reserved bit nonzero");

    // ------------------------------------------------------------
    // Checks on flags, status fields, locks, log capture and read decode
    // ------------------------------------------------------------

    AST_NRR_DISABLED: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (timeout_disable_r && !flags_r[BIT_NRR]) |=> !flags_r[BIT_NRR])
        else $error("nrr set while timeout disabled");

    AST_COMMAND_NOACK_FLAG_DISABLED: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (timeout_disable_r && !flags_r[BIT_CMD_NOACK]) |=> !flags_r[BIT_CMD_NOACK])
        else $error("command_noack_flag set while timeout disabled");

    AST_COMMAND_NOACK_FLAG_SET: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_cmd_retries_failed && !timeout_disable_r) |=> flags_r[BIT_CMD_NOACK] && flags_r[BIT_TTO])
        else $error("command_noack_flag or tto not set");

    AST_COMMAND_NOACK_FLAG_ONLY_RETRY: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (!flags_r[BIT_CMD_NOACK] && !i_cmd_retries_failed) |=> !flags_r[BIT_CMD_NOACK])
        else $error("command_noack_flag set without retry failure");

    AST_TTO_ONLY_CAUSES: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (!flags_r[BIT_TTO] && !i_grant_timeout && !i_cmd_retries_failed && !i_read_resp_timeout)
        |=> !flags_r[BIT_TTO]) else $error("tto set without cause");

    AST_CID_LOAD: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_cmd_retries_failed && !timeout_disable_r) |=> fail_cid_r == $past(i_cmd_commander_id))
        else $error("commander id not loaded");

    AST_CID_DISABLED: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_cmd_retries_failed && timeout_disable_r) |=> $stable(fail_cid_r))
        else $error("commander id loaded while timeout disabled");

    AST_SUM_CLEAR: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !i_node_err_summary |=> !status_view[BIT_NODE_SUM])
        else $error("summary bit stuck");

    AST_STF_RESET: assert property (@(posedge i_ref_clk)
        $fell(i_rst) |-> flags_r[BIT_SELF_TEST])
        else $error("self test flag not one after reset");

    AST_STF_CLEAR: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (wr_status && i_reg_wdata[BIT_SELF_TEST]) |=> !flags_r[BIT_SELF_TEST])
        else $error("self test flag not cleared");

    AST_WSE_SET: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_write_seq_err |=> flags_r[BIT_WRITE_SEQ])
        else $error("write sequence flag not set");

    AST_READ_IDENTIFY_DATA_NOACK_FLAG_SET: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_rid_data_noack |=> flags_r[BIT_RID_NOACK])
        else $error("read identify noack flag not set");

    AST_WRITE_DATA_NOACK_FLAG_SET: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_write_data_noack |=> flags_r[BIT_WD_NOACK])
        else $error("write data noack flag not set");

    AST_W1C_KEEP: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (flags_r[BIT_CRD] && !(wr_status && i_reg_wdata[BIT_CRD])) |=> flags_r[BIT_CRD])
        else $error("flag lost without write of one");

    AST_W1C_RSE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (wr_status && i_reg_wdata[BIT_RSE] && !i_read_seq_err) |=> !flags_r[BIT_RSE])
        else $error("rse not cleared");

    AST_RSVD_MASK: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (o_reg_rvalid && $past(sel_status)) |-> (o_reg_rdata & rsvd_mask) == 32'h00000000)
        else $error("reserved status bits nonzero");

    AST_TD_WRITE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        wr_status |=> timeout_disable_r == $past(i_reg_wdata[BIT_TO_DIS]))
        else $error("timeout disable not written");

    AST_FAIL_LOCK_SET: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_read_seq_err |=> fail_lock_r)
        else $error("failing log not locked");

    AST_INT_LOCK: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_internal_err |=> fail_lock_r && rsp_lock_r)
        else $error("internal error did not lock logs");

    AST_RSP_LOCK_SET: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_write_seq_err || i_rid_data_noack || i_rsp_other_err) |=> rsp_lock_r)
        else $error("responder log not locked");

    AST_FAIL_NO_CAPTURE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_cmd_ca_issued && fail_cause) |=> $stable(fail_addr_r))
        else $error("failing log captured a failing cycle");

    AST_FAIL_MOVES_ONLY: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !i_cmd_ca_issued |=> $stable(fail_addr_r))
        else $error("failing log moved without command cycle");

    AST_LEN_CAPTURE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        fail_capture |=> fail_addr_r[31:30] == $past(i_cmd_ca_data[31:30]))
        else $error("length bits not captured");

    AST_RSP_MOVES_ONLY: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !i_rsp_ca_acked |=> $stable(rsp_addr_r))
        else $error("responder log moved without acknowledge");

    AST_READ_FAIL_LOG: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_reg_rd && sel_fail) |=> o_reg_rvalid && o_reg_rdata == $past(fail_addr_r))
        else $error("failing log read wrong");

    AST_READ_RSP_LOG: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_reg_rd && sel_rsp) |=> o_reg_rvalid && o_reg_rdata == $past(rsp_addr_r))
        else $error("responder log read wrong");
endmodule : bel_bus_error_logging

/* File: test/bel_far_side.sv */
/*
 * Far-side model: other commander and responder nodes of the system bus,
 * turning one bench request into a one-cycle event pulse with its data.
 * Assumes the bench raises i_go just after a falling edge for one cycle.
 */
module bel_far_side (
    input wire logic i_ref_clk,
    input wire logic i_go,
    input wire logic [12:0] i_ev,
    input wire logic [31:0] i_data,
    input wire logic [5:0] i_cid,
    output logic [12:0] o_ev,
    output logic [31:0] o_data,
    output logic [5:0] o_cid
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_ev = 13'h0000;
        o_data = 32'h00000000;
        o_cid = 6'h00;
    end
    // Data and id lines outside a pulse show the inverse of the last value; event lines are zero
    always @(negedge i_ref_clk) begin
        o_ev <= i_go ? i_ev : 13'h0000;
        o_data <= i_go ? i_data : ~o_data;
        o_cid <= i_go ? i_cid : ~o_cid;
    end
endmodule : bel_far_side

/* File: test/testbench.sv */
/*
 * Self-checking bench for the bus error logging register bank.
 * Assumes the far-side model supplies all event pulses with their data.
 */
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin fails++; \
    $display("MISMATCH %s exp %h got %h", nm, e, a); end end
module testbench import bel_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [5:0] CID = 6'h2A;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, go = 1'b0, nes = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, fdata = 32'h0, base;
    logic [12:0] fev = 13'h0, ev;
    logic [5:0] failing_commander_id = 6'h0, cur_cid = 6'h2A, ev_cid;
    logic [31:0] ev_data, rdata;
    logic rvalid, tdis, flock, rlock;
    int fails = 0, cmp_count = 0, i;
    int kev[9] = '{1, 2, 3, 7, 10, 11, 4, 6, 5};
    logic [31:0] kmask[9] = '{32'h80000, 32'h10000, 32'h20000, 32'h100000, 32'h400000, 32'h200000,
        32'h42000, 32'h2000, 32'hA000};
    always #50 clk = ~clk;
    bel_far_side far (.i_ref_clk(clk), .i_go(go), .i_ev(fev), .i_data(fdata), .i_cid(failing_commander_id),
        .o_ev(ev), .o_data(ev_data), .o_cid(ev_cid));
    bel_bus_error_logging dut (.i_ref_clk(clk), .i_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .i_cmd_ca_issued(ev[0]), .i_cmd_ca_data(ev_data), .i_cmd_commander_id(ev_cid),
        .i_crd_resp(ev[1]), .i_read_err_resp(ev[2]), .i_read_seq_err(ev[3]),
        .i_read_resp_timeout(ev[4]), .i_cmd_retries_failed(ev[5]), .i_grant_timeout(ev[6]),
        .i_write_data_noack(ev[7]), .i_internal_err(ev[8]), .i_rsp_ca_acked(ev[9]),
        .i_rsp_ca_data(ev_data), .i_write_seq_err(ev[10]), .i_rid_data_noack(ev[11]),
        .i_rsp_other_err(ev[12]), .i_node_err_summary(nes), .o_timeout_disable(tdis),
        .o_fail_lock(flock), .o_rsp_lock(rlock));
    // ------------------------------------------------------------
    // Access, event and verdict tasks
    // ------------------------------------------------------------
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
    endtask : reg_wr
    task automatic chk(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] d;
        d = 32'hX;
        @(negedge clk);
        rd = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        if (rvalid === 1'b1) begin
            d = rdata;
        end
        `CHK(nm, e, d)
    endtask : chk
    task automatic fire(input int k, input logic [31:0] d);
        @(negedge clk);
        #1;
        fev = 13'h0001 << k;
        fdata = d;
        failing_commander_id = cur_cid;
        go = 1'b1;
        @(negedge clk);
        #1;
        go = 1'b0;
        @(negedge clk);
    endtask : fire
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        #500000;
        fails++;
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        chk(OFS_BUS_ERROR_STATUS, STATUS_RESET, "status reset");
        chk(OFS_FAILING_ADDRESS_LOG, ADDR_RESET, "fail log reset");
        $display("test reset done");
        base = STATUS_RESET;
        for (i = 0; i < 9; i++) begin
            fire(kev[i], 32'h0);
            if (kev[i] == 5) base = base | {22'h0, CID, 4'h0};
            chk(OFS_BUS_ERROR_STATUS, base | kmask[i], "flag set");
            reg_wr(OFS_BUS_ERROR_STATUS, ~kmask[i] & ~32'h00000404);
            chk(OFS_BUS_ERROR_STATUS, base | kmask[i], "flag kept");
            reg_wr(OFS_BUS_ERROR_STATUS, kmask[i]);
            chk(OFS_BUS_ERROR_STATUS, base, "flag cleared");
        end
        $display("test flags done");
        cur_cid = 6'h15;
        reg_wr(OFS_BUS_ERROR_STATUS, 32'h00000004);
        `CHK("timeout disable", 1'b1, tdis)
        for (i = 4; i < 7; i++) fire(i, 32'h0);
        chk(OFS_BUS_ERROR_STATUS, base | 32'h4, "no timeout flags");
        reg_wr(OFS_BUS_ERROR_STATUS, 32'h0);
        $display("test timeout disable done");
        fire(0, 32'hC1234567);
        chk(OFS_FAILING_ADDRESS_LOG, 32'hC1234567, "fail log load");
        fire(3, 32'h0);
        fire(0, 32'h40000BAD);
        chk(OFS_FAILING_ADDRESS_LOG, 32'hC1234567, "fail log frozen");
        `CHK("fail lock", 1'b1, flock)
        reg_wr(OFS_BUS_ERROR_STATUS, 32'h00020000);
        fire(0, 32'h87654321);
        reg_wr(OFS_FAILING_ADDRESS_LOG, 32'h0);
        chk(OFS_FAILING_ADDRESS_LOG, 32'h87654321, "fail log reload");
        $display("test failing log done");
        fire(9, 32'h3000ABCD);
        chk(OFS_RESPONDER_ERROR_ADDRESS_LOG, 32'h3000ABCD, "rsp log load");
        fire(10, 32'h0);
        fire(9, 32'h0F0F0F0F);
        chk(OFS_RESPONDER_ERROR_ADDRESS_LOG, 32'h3000ABCD, "rsp log frozen");
        `CHK("rsp lock", 1'b1, rlock)
        reg_wr(OFS_BUS_ERROR_STATUS, 32'h00400000);
        fire(9, 32'h12345678);
        chk(OFS_RESPONDER_ERROR_ADDRESS_LOG, 32'h12345678, "rsp log reload");
        chk(8'h10, 32'h0, "unmapped read");
        $display("test responder log done");
        fire(8, 32'h0);
        fire(0, 32'h0BADF00D);
        chk(OFS_FAILING_ADDRESS_LOG, 32'h87654321, "internal fail lock");
        `CHK("internal rsp lock", 1'b1, rlock)
        reg_wr(OFS_BUS_ERROR_STATUS, 32'h0);
        fire(12, 32'h0);
        fire(9, 32'h55AA55AA);
        chk(OFS_RESPONDER_ERROR_ADDRESS_LOG, 32'h12345678, "other rsp lock");
        `CHK("other no fail lock", 1'b0, flock)
        reg_wr(OFS_BUS_ERROR_STATUS, 32'h0);
        fire(9, 32'h55AA55AA);
        chk(OFS_RESPONDER_ERROR_ADDRESS_LOG, 32'h55AA55AA, "rsp lock released");
        $display("test internal locks done");
        nes = 1'b1;
        chk(OFS_BUS_ERROR_STATUS, base | 32'h1000, "node summary");
        nes = 1'b0;
        reg_wr(OFS_BUS_ERROR_STATUS, 32'hFFFFFFFF);
        chk(OFS_BUS_ERROR_STATUS, {22'h0, CID, 4'h4}, "self test cleared");
        $display("test self test done");
        give_verdict();
    end
endmodule : testbench
